// file: core/dtg_guard.sv
`timescale 1ns/1ns
`include "dtg_defines.svh"
module dtg_guard
  import dtg_pkg::*;
#(
  parameter int NGROUP  = 2,
  parameter int NBANK   = 4,
  parameter int REFI    = (`DTG_REFI_PS + `DTG_CLK_PS - 1) / `DTG_CLK_PS,
  parameter int REFI_HT = (`DTG_REFI_HOT_PS + `DTG_CLK_PS - 1) / `DTG_CLK_PS,
  parameter int TW      = 12
) (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RSTN,
  // command request from the scheduler
  input  wire logic       REQ_VALID,
  input  dtg_pkg::dtg_cmd_t REQ_CMD,
  input  wire logic [0:0] REQ_BG,
  input  wire logic [1:0] REQ_BA,
  input  wire logic       REQ_ABORT,
  output logic            REQ_READY,
  // mode settings
  input  wire logic       CRC_DM_EN,
  input  wire logic       CAL_EN,
  input  wire logic       HOT,
  // command bus to the memory
  output logic            CS_N,
  output logic            CKE,
  output logic            CK_EN,
  output dtg_pkg::dtg_cmd_t MEM_CMD,
  output logic [0:0]      MEM_BG,
  output logic [1:0]      MEM_BA,
  output logic            REF_DUE
);
  import dtg_pkg::*;
  localparam int NB = NGROUP * NBANK;

  initial begin
    if (NGROUP != 2 || NBANK != 4) $error("dtg_guard: only 2 groups of 4 banks served");
    if (REFI >= (1 << TW) * 2 || REFI_HT < 2) $error("dtg_guard: refresh interval unfit");
  end

  // cycle counts
  localparam logic [TW-1:0] C_CCDL = TW'(`DTG_CYC(`DTG_CCD_L_PS, `DTG_CCD_L_NCK));
  localparam logic [TW-1:0] C_CCDS = TW'(`DTG_CCD_S_NCK);
  localparam logic [TW-1:0] C_RRDS = TW'(`DTG_CYC(`DTG_RRD_S_PS, `DTG_RRD_NCK));
  localparam logic [TW-1:0] C_RRDL = TW'(`DTG_CYC(`DTG_RRD_L_PS, `DTG_RRD_NCK));
  localparam logic [TW-1:0] C_FAW  = TW'(`DTG_CYC(`DTG_FAW_PS, `DTG_FAW_NCK));
  localparam logic [TW-1:0] C_CRC  = TW'(`DTG_CYC(`DTG_CRCDM_PS, `DTG_CRCDM_NCK));
  localparam logic [TW-1:0] C_WTRS = TW'(`DTG_CYC(`DTG_WTR_S_PS, `DTG_WTR_S_NCK));
  localparam logic [TW-1:0] C_WTRL = TW'(`DTG_CYC(`DTG_WTR_L_PS, `DTG_WTR_L_NCK));
  localparam logic [TW-1:0] C_RTP  = TW'(`DTG_CYC(`DTG_RTP_PS, `DTG_RTP_NCK));
  localparam logic [TW-1:0] C_WR   = TW'(`DTG_CYC(`DTG_WR_PS, 1));
  localparam logic [TW-1:0] C_RP   = TW'(`DTG_CYC(`DTG_RP_PS, 1));
  localparam logic [TW-1:0] C_MRD  = TW'(`DTG_MRD_NCK);
  localparam logic [TW-1:0] C_MOD  = TW'(`DTG_CYC(`DTG_MOD_PS, `DTG_MOD_NCK));
  localparam logic [TW-1:0] C_ZQI  = TW'(`DTG_ZQINIT_NCK);
  localparam logic [TW-1:0] C_ZQL  = TW'(`DTG_ZQOPER_NCK);
  localparam logic [TW-1:0] C_ZQS  = TW'(`DTG_ZQCS_NCK);
  localparam logic [TW-1:0] C_XPR  =
    TW'(`DTG_CYC(`DTG_RFC_PS + `DTG_XS_ADD_PS, `DTG_XPR_NCK));
  localparam logic [TW-1:0] C_XS   = TW'(`DTG_CYC(`DTG_RFC_PS + `DTG_XS_ADD_PS, 1));
  localparam logic [TW-1:0] C_XSAB = TW'(`DTG_CYC(`DTG_RFC4_PS + `DTG_XS_ADD_PS, 1));
  localparam logic [TW-1:0] C_DLLK = TW'(`DTG_DLLK_NCK);
  localparam logic [TW-1:0] C_CKSR = TW'(`DTG_CYC(`DTG_CKE_PS, `DTG_CKE_NCK) + 1);
  localparam logic [TW-1:0] C_MPED = C_MOD + TW'(`DTG_CPDED_NCK);
  localparam logic [TW-1:0] C_CALL = TW'(`DTG_CAL_NCK);

  // decode of the offered command
  wire is_col  = REQ_CMD inside {DTG_RD, DTG_WR, DTG_WRA};
  wire is_rd   = REQ_CMD == DTG_RD;
  wire is_wr   = REQ_CMD inside {DTG_WR, DTG_WRA};
  wire is_act  = REQ_CMD == DTG_ACT;
  wire is_pre  = REQ_CMD == DTG_PRE;
  wire is_mrs  = REQ_CMD == DTG_MRS;
  wire is_zq   = REQ_CMD inside {DTG_ZQL, DTG_ZQS};
  wire is_dll  = is_col;
  wire [2:0] bidx = {REQ_BG, REQ_BA};

  dtg_state_t state_ff, nxt_state;
  logic [2:0] actcnt_ff;
  logic [TW-1:0] faw_ff [4];
  logic [TW:0]   refi_ff;
  logic [2:0]    cal_ff;
  logic          pend_ff;
  dtg_cmd_t      pcmd_ff;
  logic [0:0]    pbg_ff;
  logic [1:0]    pba_ff;

  // timers: index 0..1 same-group column, 2..3 same-group act, 4..5 write-to-read
  // same group, then device wide entries, then per bank read/write-to-precharge
  localparam int T_CCS = 6, T_RRS = 7, T_WTS = 8, T_MRD = 9, T_MOD = 10;
  localparam int T_ALL = 11, T_DLL = 12, T_CKL = 13, T_BK = 14, NT = T_BK + NB;
  logic [NT-1:0]  busy;
  logic [NT-1:0]  load;
  logic [TW-1:0]  val [NT];

  wire take = REQ_VALID && REQ_READY;
  wire [TW-1:0] crc_add = CRC_DM_EN ? C_CRC : '0;

  // blocking checks, group local and device wide
  wire blk_col = is_col && (busy[REQ_BG] || busy[T_CCS]);
  wire blk_act = is_act && (busy[2 + REQ_BG] || busy[T_RRS] || actcnt_ff == 3'd4);
  // a bank closing by auto-precharge may not be opened again early
  wire blk_bnk = is_act && busy[T_BK + bidx];
  wire blk_rd  = is_rd && (busy[4 + REQ_BG] || busy[T_WTS]);
  wire blk_pre = is_pre && busy[T_BK + bidx];
  wire blk_mrs = is_mrs && busy[T_MRD];
  wire blk_mod = !is_mrs && busy[T_MOD];
  wire blk_dll = is_dll && busy[T_DLL];
  wire blk_srx = REQ_CMD == DTG_SRX && busy[T_CKL];
  wire blk_st  = (state_ff == DTG_ST_SR) ? REQ_CMD != DTG_SRX :
                 (state_ff == DTG_ST_MPS) || (state_ff == DTG_ST_INIT);
  wire blocked = busy[T_ALL] || blk_col || blk_act || blk_bnk || blk_rd || blk_pre || blk_mrs ||
                 blk_mod || blk_dll || blk_srx || blk_st || pend_ff;

  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : g_tmr
      dtg_down_counter #(.W(TW)) u_tmr (
        .clk   (CLK),
        .rstn  (RSTN),
        .load  (load[g]),
        .value (val[g]),
        .busy  (busy[g])
      );
    end
  endgenerate

  // timer loads for each accepted command but precharge and refresh, and for the init waits
  always_comb begin
    load = '0;
    for (int i = 0; i < NT; i++) val[i] = '0;
    if (take && is_col) begin
      load[REQ_BG] = 1'b1;
      val[REQ_BG] = C_CCDL;
      load[T_CCS] = 1'b1;
      val[T_CCS] = C_CCDS;
    end
    if (take && is_act) begin
      load[2 + REQ_BG] = 1'b1;
      val[2 + REQ_BG] = C_RRDL;
      load[T_RRS] = 1'b1;
      val[T_RRS] = C_RRDS;
    end
    if (take && is_wr) begin
      load[4 + REQ_BG] = 1'b1;
      val[4 + REQ_BG] = C_WTRL + crc_add;
      load[T_WTS] = 1'b1;
      val[T_WTS] = C_WTRS + crc_add;
      load[T_BK + bidx] = 1'b1;
      val[T_BK + bidx] = (REQ_CMD == DTG_WRA) ? C_WR + crc_add + C_RP
                                              : C_WR + crc_add;
    end
    if (take && is_rd) begin
      load[T_BK + bidx] = 1'b1;
      val[T_BK + bidx] = C_RTP;
    end
    if (take && is_mrs) begin
      load[T_MRD] = 1'b1;
      val[T_MRD] = C_MRD;
      load[T_MOD] = 1'b1;
      val[T_MOD] = C_MOD;
    end
    if (state_ff == DTG_ST_INIT && cal_ff == 3'd0) begin
      load[T_ALL] = 1'b1;
      val[T_ALL] = C_XPR;
    end
    // initial calibration starts only once the reset exit wait is over
    if (state_ff == DTG_ST_INIT && cal_ff == 3'd1 && !busy[T_ALL]) begin
      load[T_ALL] = 1'b1;
      val[T_ALL] = C_ZQI;
    end
    if (take && is_zq) begin
      load[T_ALL] = 1'b1;
      val[T_ALL] = (REQ_CMD == DTG_ZQL) ? C_ZQL : C_ZQS;
    end
    if (take && REQ_CMD == DTG_SRX) begin
      load[T_ALL] = 1'b1;
      val[T_ALL] = REQ_ABORT ? C_XSAB : C_XS;
      load[T_DLL] = 1'b1;
      val[T_DLL] = C_DLLK;
    end
    if (take && REQ_CMD == DTG_SRE) begin
      load[T_CKL] = 1'b1;
      val[T_CKL] = C_CKSR;
    end
    if (take && REQ_CMD == DTG_MPSM) begin
      load[T_CKL] = 1'b1;
      // the clock gate is registered, so it lands one edge after the timer ends
      val[T_CKL] = C_MPED + TW'(1);
    end
  end

  // state walk: init holds off until reset exit and initial calibration are done
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      DTG_ST_INIT: if (cal_ff == 3'd2 && !busy[T_ALL]) nxt_state = DTG_ST_RUN;
      DTG_ST_RUN: begin
        if (take && REQ_CMD == DTG_SRE)  nxt_state = DTG_ST_SR;
        if (take && REQ_CMD == DTG_MPSM) nxt_state = DTG_ST_MPS;
      end
      DTG_ST_SR:  if (take) nxt_state = DTG_ST_RUN;
      DTG_ST_MPS: nxt_state = DTG_ST_MPS;
    endcase
  end

  // four-activate window: one slot per activate in flight
  logic [3:0] faw_exp;
  logic [3:0] faw_free;
  logic [3:0] faw_pick;
  // only the lowest free slot takes a new activate
  always_comb begin
    faw_pick = '0;
    for (int i = 0; i < 4; i++) begin
      faw_exp[i]  = (faw_ff[i] == TW'(1));
      faw_free[i] = (faw_ff[i] == '0) || faw_exp[i];
      if (faw_free[i] && faw_pick == '0) faw_pick[i] = 1'b1;
    end
  end
  wire [2:0] nxt_actcnt = actcnt_ff + 3'(take && is_act)
                          - 3'(faw_exp[0]) - 3'(faw_exp[1]) - 3'(faw_exp[2]) - 3'(faw_exp[3]);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff  <= DTG_ST_INIT;
      actcnt_ff <= 3'd0;
      cal_ff    <= 3'd0;
      for (int i = 0; i < 4; i++) faw_ff[i] <= '0;
    end else begin
      state_ff  <= nxt_state;
      actcnt_ff <= nxt_actcnt;
      if (state_ff == DTG_ST_INIT && cal_ff < 3'd2 && (cal_ff == 3'd0 || !busy[T_ALL]))
        cal_ff <= cal_ff + 3'd1;
      for (int i = 0; i < 4; i++) begin
        if (faw_ff[i] != '0) faw_ff[i] <= faw_ff[i] - 1'b1;
      end
      for (int i = 0; i < 4; i++) begin
        if (take && is_act && faw_pick[i]) faw_ff[i] <= C_FAW - TW'(2);
      end
    end
  end

  // refresh interval, hot case halves it
  wire [TW:0] refi_lim = HOT ? (TW+1)'(REFI_HT) : (TW+1)'(REFI);
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      refi_ff <= '0;
      REF_DUE <= 1'b0;
    end else begin
      // free running, so scheduler latency never stretches the average interval
      refi_ff <= (refi_ff >= refi_lim - 1'b1) ? '0 : refi_ff + 1'b1;
      if (refi_ff >= refi_lim - 1'b1) REF_DUE <= 1'b1;
      else if (take && REQ_CMD == DTG_REF) REF_DUE <= 1'b0;
    end
  end

  // select latency: chip select leads the command by a fixed gap
  logic [TW-1:0] lat_ff;
  wire issue_now = pend_ff && (lat_ff == TW'(1));
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pend_ff   <= 1'b0;
      lat_ff    <= '0;
      pcmd_ff   <= DTG_NOP;
      pbg_ff    <= '0;
      pba_ff    <= '0;
      REQ_READY <= 1'b0;
      CS_N      <= 1'b1;
      CKE       <= 1'b0;
      CK_EN     <= 1'b1;
      MEM_CMD   <= DTG_NOP;
      MEM_BG    <= '0;
      MEM_BA    <= '0;
    end else begin
      REQ_READY <= !blocked && !take && !(CAL_EN && take);
      CS_N      <= 1'b1;
      MEM_CMD   <= DTG_NOP;
      CKE       <= (state_ff == DTG_ST_SR || state_ff == DTG_ST_MPS) ? 1'b0 : 1'b1;
      // power save keeps the clock only while the mode update plus path-disable wait runs
      CK_EN     <= !(state_ff == DTG_ST_MPS && !busy[T_CKL]);
      if (take && CAL_EN) begin
        pend_ff <= 1'b1;
        lat_ff  <= C_CALL;
        pcmd_ff <= REQ_CMD;
        pbg_ff  <= REQ_BG;
        pba_ff  <= REQ_BA;
        CS_N    <= 1'b0;
      end else if (take) begin
        CS_N    <= 1'b0;
        MEM_CMD <= REQ_CMD;
        MEM_BG  <= REQ_BG;
        MEM_BA  <= REQ_BA;
      end
      if (pend_ff) begin
        lat_ff <= lat_ff - 1'b1;
        if (issue_now) begin
          pend_ff <= 1'b0;
          MEM_CMD <= pcmd_ff;
          MEM_BG  <= pbg_ff;
          MEM_BA  <= pba_ff;
        end
      end
    end
  end
endmodule : dtg_guard

// file: core/dtg_defines.svh
`ifndef DTG_DEFINES_SVH
`define DTG_DEFINES_SVH
// clock of this block, picoseconds per cycle
`define DTG_CLK_PS            4000
// rounding of a minimum time in ps up to cycles, never below the cycle floor
`define DTG_CYC(ps, nck)      (((((ps) + `DTG_CLK_PS - 1) / `DTG_CLK_PS) > (nck)) ? \
                               (((ps) + `DTG_CLK_PS - 1) / `DTG_CLK_PS) : (nck))
// times as printed, in picoseconds, with their cycle floors
`define DTG_CCD_L_PS          5000
`define DTG_CCD_L_NCK         5
`define DTG_CCD_S_NCK         4
`define DTG_RRD_S_PS          5300
`define DTG_RRD_L_PS          6400
`define DTG_RRD_NCK           4
`define DTG_FAW_PS            30000
`define DTG_FAW_NCK           28
`define DTG_WTR_S_PS          2500
`define DTG_WTR_S_NCK         2
`define DTG_WTR_L_PS          7500
`define DTG_WTR_L_NCK         4
`define DTG_CRCDM_PS          3750
`define DTG_CRCDM_NCK         5
`define DTG_RTP_PS            7500
`define DTG_RTP_NCK           4
`define DTG_WR_PS             15000
`define DTG_RP_PS             14160
`define DTG_MRD_NCK           8
`define DTG_MOD_PS            15000
`define DTG_MOD_NCK           24
`define DTG_CAL_NCK           5
`define DTG_ZQINIT_NCK        1024
`define DTG_ZQOPER_NCK        512
`define DTG_ZQCS_NCK          128
`define DTG_RFC_PS            260000
`define DTG_RFC4_PS           110000
`define DTG_XS_ADD_PS         10000
`define DTG_XPR_NCK           5
`define DTG_DLLK_NCK          768
`define DTG_CKE_PS            5000
`define DTG_CKE_NCK           3
`define DTG_CPDED_NCK         4
`define DTG_REFI_PS           7800000
`define DTG_REFI_HOT_PS       3900000
`endif

// file: core/dtg_pkg.sv
package dtg_pkg;
  typedef enum logic [3:0] {
    DTG_NOP  = 4'h0,
    DTG_ACT  = 4'h1,
    DTG_RD   = 4'h2,
    DTG_WR   = 4'h3,
    DTG_WRA  = 4'h4,
    DTG_PRE  = 4'h5,
    DTG_REF  = 4'h6,
    DTG_MRS  = 4'h7,
    DTG_ZQL  = 4'h8,
    DTG_ZQS  = 4'h9,
    DTG_SRE  = 4'ha,
    DTG_SRX  = 4'hb,
    DTG_MPSM = 4'hc
  } dtg_cmd_t;
  typedef enum logic [1:0] {
    DTG_ST_INIT = 2'b00,
    DTG_ST_RUN  = 2'b01,
    DTG_ST_SR   = 2'b10,
    DTG_ST_MPS  = 2'b11
  } dtg_state_t;
endpackage : dtg_pkg

// file: core/dtg_down_counter.sv
`timescale 1ns/1ns
// one gap timer: loads on a start pulse, never shortens a pending wait
module dtg_down_counter #(
  parameter int W = 11
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              busy
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  wire          dec = (cnt_ff != '0);

  always_comb begin
    nxt_cnt = dec ? cnt_ff - 1'b1 : cnt_ff;
    // a load counts its own cycle and the registered ready costs one more,
    // so value-2 further cycles put the next take exactly value cycles later
    if (load && (value - W'(2)) > nxt_cnt) begin
      nxt_cnt = value - W'(2);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt_ff <= '0;
    else       cnt_ff <= nxt_cnt;
  end

  assign busy = dec;
endmodule : dtg_down_counter

// file: testbench/dtg_guard_sva.sv
`timescale 1ns/1ns
module dtg_guard_chk
  import dtg_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // request side
  input  wire logic        REQ_VALID,
  input  dtg_pkg::dtg_cmd_t REQ_CMD,
  input  wire logic        REQ_ABORT,
  input  wire logic        REQ_READY,
  input  wire logic        CRC_DM_EN,
  input  wire logic        CAL_EN,
  // memory side
  input  wire logic        CS_N,
  input  wire logic        CKE,
  input  dtg_pkg::dtg_cmd_t MEM_CMD,
  input  wire logic [0:0]  MEM_BG,
  input  wire logic [1:0]  MEM_BA
);
  // age of last column, act, write, read, mode set, zq long, zq short, srx, cke rise
  logic [10:0] age_ff [9];
  logic [2:0]  bnk_ff [4];
  logic        cke_ff;
  logic        abort_ff;
  logic        seen_ff;
  logic [8:0]  hit;
  wire         cmd_on = MEM_CMD != DTG_NOP;
  wire         col    = MEM_CMD inside {DTG_RD, DTG_WR, DTG_WRA};
  wire  [2:0]  here   = {MEM_BG, MEM_BA};
  assign hit = {CKE && !cke_ff, MEM_CMD == DTG_SRX, MEM_CMD == DTG_ZQS, MEM_CMD == DTG_ZQL,
                MEM_CMD == DTG_MRS, MEM_CMD == DTG_RD, MEM_CMD inside {DTG_WR, DTG_WRA},
                MEM_CMD == DTG_ACT, col};
  // ages saturate so a long quiet spell never wraps into a false short gap
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < 9; i++) age_ff[i] <= 11'h7ff;
      for (int i = 0; i < 4; i++) bnk_ff[i] <= 3'h0;
      cke_ff <= 1'b0;
      abort_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      for (int i = 0; i < 9; i++) begin
        if (hit[i]) age_ff[i] <= 11'h1;
        else if (age_ff[i] != 11'h7ff) age_ff[i] <= age_ff[i] + 11'h1;
      end
      for (int i = 0; i < 4; i++) if (hit[i]) bnk_ff[i] <= here;
      cke_ff <= CKE;
      seen_ff <= seen_ff | cmd_on;
      if (REQ_VALID && REQ_READY && REQ_CMD == DTG_SRX) abort_ff <= REQ_ABORT;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence cmd_seen;
    cmd_on;
  endsequence
  sequence select_low;
    !CS_N;
  endsequence
  property cal_lat;
    select_low |-> if (CAL_EN) (##5 cmd_seen) else cmd_seen;
  endproperty

  same_group_col_a: assert property (col && here[2] == bnk_ff[0][2] |-> age_ff[0] >= 11'h5)
    else $error("column gap in one group too short");
  cross_group_col_a: assert property (col |-> age_ff[0] >= 11'h4)
    else $error("column gap too short");
  act_gap_a: assert property (MEM_CMD == DTG_ACT |-> age_ff[1] >= 11'h4)
    else $error("activate gap too short");
  write_to_read_a: assert property (MEM_CMD == DTG_RD |-> age_ff[2] >=
      (here[2] == bnk_ff[2][2] ? (CRC_DM_EN ? 11'h9 : 11'h4) : (CRC_DM_EN ? 11'h7 : 11'h2)))
    else $error("read too soon after write");
  read_to_pre_a: assert property (MEM_CMD == DTG_PRE && here == bnk_ff[3] |-> age_ff[3] >= 11'h4)
    else $error("precharge too soon after read");
  mode_set_gap_a: assert property (MEM_CMD == DTG_MRS |-> age_ff[4] >= 11'h8)
    else $error("mode set commands too close");
  mode_update_a: assert property (cmd_on && MEM_CMD != DTG_MRS |-> age_ff[4] >= 11'h18)
    else $error("command before mode update wait");
  calib_wait_a: assert property (cmd_on |-> age_ff[5] >= 11'h200 && age_ff[6] >= 11'h80)
    else $error("command inside calibration time");
  select_latency_a: assert property (cal_lat)
    else $error("command not at select latency");
  init_calib_a: assert property (cmd_on && !seen_ff |-> age_ff[8] >= 11'h400)
    else $error("first command inside initial calibration");
  srx_wait_a: assert property (cmd_on |-> age_ff[7] >=
      ((abort_ff || MEM_CMD inside {DTG_ZQL, DTG_ZQS, DTG_MRS}) ? 11'h1e : 11'h44))
    else $error("command too soon after self refresh exit");
  dll_lock_a: assert property (MEM_CMD inside {DTG_RD, DTG_WR, DTG_WRA} |-> age_ff[7] >= 11'h300)
    else $error("data command before loop lock");
endmodule : dtg_guard_chk

bind dtg_guard dtg_guard_chk u_chk (.CLK(CLK), .RSTN(RSTN), .REQ_VALID(REQ_VALID),
  .REQ_CMD(REQ_CMD), .REQ_ABORT(REQ_ABORT), .REQ_READY(REQ_READY), .CRC_DM_EN(CRC_DM_EN),
  .CAL_EN(CAL_EN), .CS_N(CS_N), .CKE(CKE), .MEM_CMD(MEM_CMD), .MEM_BG(MEM_BG), .MEM_BA(MEM_BA));

// file: testbench/dtg_mem_model.sv
`timescale 1ns/1ns
module dtg_mem_model
  import dtg_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // command bus at the device pins
  input  wire logic        cs_n,
  input  wire logic        cal_en,
  input  wire logic        ck_en,
  input  dtg_pkg::dtg_cmd_t cmd,
  // tallies for the bench
  output int               n_cmd,
  output int               n_err
);
  logic [4:0] sel_ff;
  int         quiet;
  int         mps_age;
  wire        take = cal_en ? sel_ff[4] : !cs_n;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_ff <= 5'h0;
      quiet <= 1024;
      mps_age <= 0;
      n_cmd <= 0;
      n_err <= 0;
    end else begin
      sel_ff <= {sel_ff[3:0], !cs_n};
      if (quiet > 0) quiet <= quiet - 1;
      if (mps_age > 0) mps_age <= mps_age + 1;
      // a command landing inside calibration spoils it
      if (take) begin
        n_cmd <= n_cmd + 1;
        if (quiet > 0) n_err <= n_err + 1;
        if (cmd == DTG_ZQL) quiet <= 511;
        if (cmd == DTG_ZQS) quiet <= 127;
        if (cmd == DTG_MPSM) mps_age <= 1;
      end
      // the path shuts down only if the clock lives through update plus disable
      if (!ck_en && mps_age < 28) n_err <= n_err + 1;
    end
  end
endmodule : dtg_mem_model

// file: testbench/dtg_guard_tb.sv
`timescale 1ns/1ns
module dtg_guard_tb;
  import dtg_pkg::*;
  localparam int       refi_cyc     = 6000;
  localparam int       refi_hot_cyc = 3000;
  localparam dtg_cmd_t pool [4]     = '{DTG_ACT, DTG_RD, DTG_WR, DTG_PRE};
  logic       clk, rstn, valid, abort, crc, cal, hot, ready, cs_n, ck_en, ref_due;
  dtg_cmd_t   cmd, mcmd;
  logic [0:0] bg;
  logic [1:0] ba;
  int         cyc, n_fail, cmp_count, n_take, t0, t1, d, seed, nm, ne;

  dtg_guard #(.REFI(refi_cyc), .REFI_HT(refi_hot_cyc)) u_dut (
    .CLK(clk), .RSTN(rstn), .REQ_VALID(valid), .REQ_CMD(cmd), .REQ_BG(bg),
    .REQ_BA(ba), .REQ_ABORT(abort), .REQ_READY(ready), .CRC_DM_EN(crc),
    .CAL_EN(cal), .HOT(hot), .CS_N(cs_n), .CKE(), .CK_EN(ck_en),
    .MEM_CMD(mcmd), .MEM_BG(), .MEM_BA(), .REF_DUE(ref_due));
  dtg_mem_model u_mem (.clk(clk), .rstn(rstn), .cs_n(cs_n), .cal_en(cal), .ck_en(ck_en),
    .cmd(mcmd), .n_cmd(nm), .n_err(ne));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // entered at a falling edge; valid stays up so back-to-back offers lose no cycle
  task automatic issue(input dtg_cmd_t c, input logic [2:0] b, output int t);
    int n;
    n = 0;
    valid = 1'b1;
    cmd = c;
    {bg, ba} = b;
    do begin
      @(posedge clk);
      n++;
    end while (ready !== 1'b1 && n < 3000);
    t = cyc;
    n_take++;
    @(negedge clk);
  endtask : issue

  task automatic idle(input int n);
    valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic gap(input dtg_cmd_t a, input logic [2:0] ab, input dtg_cmd_t b,
                     input logic [2:0] bb, input int exp);
    idle(40);
    issue(a, ab, t0);
    issue(b, bb, t1);
    check(t1 - t0, exp);
  endtask : gap

  task automatic due(output int t);
    int n;
    n = 0;
    while (ref_due !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    t = cyc;
    @(negedge clk);
  endtask : due

  task automatic span(output int s);
    int a;
    issue(DTG_REF, 3'h0, a);
    idle(2);
    due(a);
    issue(DTG_REF, 3'h0, s);
    idle(2);
    due(s);
    s = s - a;
  endtask : span

  initial begin
    #(4 * 60000);
    n_fail++;
    end_of_test();
  end

  initial begin
    {valid, abort, crc, cal, hot, bg, ba} = '0;
    cmd = DTG_NOP;
    {cyc, n_fail, cmp_count, n_take} = '0;
    seed = 32'h5dec150d;
    rstn = 1'b0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    t0 = cyc;
    issue(DTG_MRS, 3'h0, t1);
    check(t1 - t0 >= 1092, 32'h1);
    gap(DTG_RD, 3'h0, DTG_RD, 3'h1, 5);
    gap(DTG_RD, 3'h0, DTG_WR, 3'h4, 4);
    gap(DTG_ACT, 3'h0, DTG_ACT, 3'h4, 4);
    gap(DTG_ACT, 3'h0, DTG_ACT, 3'h1, 4);
    gap(DTG_RD, 3'h6, DTG_PRE, 3'h6, 4);
    gap(DTG_WRA, 3'h3, DTG_ACT, 3'h3, 8);
    gap(DTG_MRS, 3'h0, DTG_MRS, 3'h0, 8);
    gap(DTG_MRS, 3'h0, DTG_ACT, 3'h0, 24);
    gap(DTG_ZQL, 3'h0, DTG_ACT, 3'h0, 512);
    gap(DTG_ZQS, 3'h0, DTG_ACT, 3'h0, 128);
    crc = 1'b1;
    gap(DTG_WR, 3'h0, DTG_RD, 3'h4, 7);
    gap(DTG_WR, 3'h0, DTG_RD, 3'h1, 9);
    crc = 1'b0;
    idle(40);
    issue(DTG_ACT, 3'h0, t0);
    for (int i = 1; i < 5; i++) issue(DTG_ACT, 3'(i * 3), t1);
    check(t1 - t0, 28);
    idle(40);
    issue(DTG_SRE, 3'h0, t1);
    issue(DTG_SRX, 3'h0, t0);
    check(t0 - t1, 4);
    issue(DTG_ACT, 3'h0, t1);
    check(t1 - t0, 68);
    issue(DTG_RD, 3'h0, t1);
    check(t1 - t0, 768);
    idle(40);
    issue(DTG_SRE, 3'h0, t0);
    abort = 1'b1;
    issue(DTG_SRX, 3'h0, t0);
    abort = 1'b0;
    issue(DTG_ACT, 3'h0, t1);
    check(t1 - t0, 30);
    idle(800);
    // random traffic with select latency on; the checker judges the column, activate, write-to-read and read-to-precharge gaps
    cal = 1'b1;
    for (int i = 0; i < 40; i++) issue(pool[$unsigned($random(seed)) % 4], 3'($random(seed)), t1);
    idle(10);
    cal = 1'b0;
    due(t0);
    span(d);
    check(d, refi_cyc);
    hot = 1'b1;
    span(d);
    span(d);
    check(d, refi_hot_cyc);
    issue(DTG_MPSM, 3'h0, t0);
    idle(60);
    check(nm, n_take);
    check(ne, 0);
    end_of_test();
  end
endmodule : dtg_guard_tb
